// *** fpa_pkg.sv ***
// Package for the flash program memory access block.
// Assumes a 32-bit Avalon-MM register bus with word-aligned byte addresses.
package fpa_pkg;
    localparam logic [5:0] OFS_DATA_LOW = 6'h00;
    localparam logic [5:0] OFS_DATA_HIGH = 6'h04;
    localparam logic [5:0] OFS_ADDR_LOW = 6'h08;
    localparam logic [5:0] OFS_ADDR_HIGH = 6'h0c;
    localparam logic [5:0] OFS_CONTROL = 6'h10;
    localparam logic [5:0] OFS_UNLOCK = 6'h14;
    localparam int CTL_RD = 0;
    localparam int CTL_WR = 1;
    localparam int CTL_WREN = 2;
    localparam int CTL_WRERR = 3;
    localparam int CTL_FREE = 4;
    localparam int CTL_LWLO = 5;
    localparam int CTL_CONFIG_SPACE_SELECT = 6;
    localparam logic [7:0] UNLOCK_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_SECOND = 8'haa;
    localparam logic [7:0] ADDR_HIGH_FILL = 8'h80;
    localparam logic [7:0] DATA_HIGH_MASK = 8'h3f;
    localparam logic [15:0] CFG_BASE = 16'h8000;
    localparam logic [15:0] CFG_USER_ID_LAST = 16'h8003;
    localparam logic [15:0] CFG_DEV_ID = 16'h8006;
    localparam logic [15:0] CFG_WORD_FIRST = 16'h8007;
    localparam logic [15:0] CFG_WORD_LAST = 16'h8008;
    localparam logic [31:0] BUS_UNMAPPED = 32'h0000_0000;
    localparam logic [7:0] ADDR_RESET = 8'h00;
    typedef enum logic [1:0]
    {
        FPA_IDLE = 2'b00,
        FPA_REQ = 2'b01,
        FPA_WAIT = 2'b11
    } fpa_state_t;
endpackage

// *** fpa_cfg_decode.sv ***
// Configuration-space access decode for an effective 16-bit address.
// Pure combinational; fed from the address registers of the top.
`timescale 1ns/1ps
module fpa_cfg_decode
    import fpa_pkg::*;
(
    input wire logic cfg_sel,
    input wire logic [15:0] eff_addr,
    output logic rd_ok,
    output logic wr_ok
);
    always_comb
    begin
        rd_ok = 1'b1;
        wr_ok = 1'b1;
        if (cfg_sel)
        begin
            wr_ok = eff_addr >= CFG_BASE && eff_addr <= CFG_USER_ID_LAST;
            rd_ok = wr_ok || (eff_addr == CFG_DEV_ID)
                || (eff_addr >= CFG_WORD_FIRST && eff_addr <= CFG_WORD_LAST);
        end
    end
endmodule

// *** fpa_unlock.sv ***
// Unlock sequence tracker: 55h then aa written to the unlock register.
// Assumes writes arrive as single-cycle strobes from the bus slave.
`timescale 1ns/1ps
module fpa_unlock
    import fpa_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic wr_stb,
    input wire logic [7:0] wr_data,
    input wire logic consume,
    output logic armed
);
    logic first_q;
    logic armed_q;
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            first_q <= 1'b0;
            armed_q <= 1'b0;
        end
        else if (wr_stb)
        begin
            // Any other value breaks the sequence
            first_q <= (wr_data == UNLOCK_FIRST);
            armed_q <= first_q && (wr_data == UNLOCK_SECOND);
        end
        else if (consume)
        begin
            first_q <= 1'b0;
            armed_q <= 1'b0;
        end
    end
    assign armed = armed_q;
endmodule

// *** fpa_top.sv ***
// Flash program memory self-access: address/data registers, control
// and unlock over Avalon-MM, and a simple array request port.
// Assumes the array answers each request with a one-cycle done pulse.
`timescale 1ns/1ps
// Operation
// - Select bit set steers reads and writes to configuration space.
// - Configuration space is the region with address bit 15 set.
// - A configuration read outside the allowed set clears both data bytes.
// - User ID words 8000h to 8003h are readable and writable.
// - ID word 8006h and config words 8007h-8008h are read-only.
// - Data low holds word bits 7..0, not cleared by reset.
// - Data high holds bits 13..8 in bits 5..0, bits 7..6 read zero.
// - Address low holds bits 7..0 and clears on reset.
// - Address high holds bits 14..8, clears, bit 7 reads as one.
module fpa_top
    import fpa_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic arr_req,
    output logic arr_we,
    output logic arr_erase,
    output logic arr_latch_only,
    output logic [15:0] arr_addr,
    output logic [13:0] arr_wdata,
    input wire logic [13:0] arr_rdata,
    input wire logic arr_done,
    input wire logic arr_fail
);
    logic [7:0] data_low_q;
    logic [5:0] data_high_q;
    logic [7:0] addr_low_q;
    logic [6:0] addr_high_q;
    logic config_space_select_q;
    logic lwlo_q;
    logic free_q;
    logic wrerr_q;
    logic wren_q;
    logic wr_q;
    logic rd_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [15:0] eff_addr;
    logic rd_ok;
    logic wr_ok;
    logic armed;
    logic wr_go;
    logic bus_wr;
    logic bus_rd;
    logic unlock_stb;
    logic cap_rd;
    logic [7:0] ctl_view;
    fpa_state_t state_q;

    function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
        hit = (a == o);
    endfunction

    // One wait state: each access completes the cycle after it is seen
    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    // Writes commit only at the edge that sees waitrequest low
    assign bus_wr = avs_write && ack_q && avs_byteenable[0];
    assign bus_rd = avs_read && !ack_q;
    assign unlock_stb = bus_wr && hit(avs_address, OFS_UNLOCK);

    assign eff_addr = config_space_select_q ? (CFG_BASE | {1'b0, addr_high_q, addr_low_q})
                             : {1'b0, addr_high_q, addr_low_q};

    fpa_cfg_decode u_dec
    (
        .cfg_sel(config_space_select_q),
        .eff_addr(eff_addr),
        .rd_ok(rd_ok),
        .wr_ok(wr_ok)
    );

    fpa_unlock u_unl
    (
        .mclk(mclk),
        .rst_b(rst_b),
        .wr_stb(unlock_stb),
        .wr_data(avs_writedata[7:0]),
        .consume(wr_go),
        .armed(armed)
    );

    // WR only starts when enabled, unlocked and idle
    assign wr_go = bus_wr && hit(avs_address, OFS_CONTROL)
        && avs_writedata[CTL_WR] && wren_q && armed && !wr_q && !rd_q;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            ack_q <= 1'b0;
        else
            ack_q <= (avs_read || avs_write) && !ack_q;
    end

    assign ctl_view = {1'b1, config_space_select_q, lwlo_q, free_q, wrerr_q, wren_q,
                       wr_q, rd_q};

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            rdata_q <= BUS_UNMAPPED;
        else if (bus_rd)
        begin
            case (avs_address)
                OFS_DATA_LOW: rdata_q <= {24'h0, data_low_q};
                OFS_DATA_HIGH: rdata_q <= {26'h0, data_high_q};
                OFS_ADDR_LOW: rdata_q <= {24'h0, addr_low_q};
                OFS_ADDR_HIGH: rdata_q <= {24'h0,
                    ADDR_HIGH_FILL | {1'b0, addr_high_q}};
                OFS_CONTROL: rdata_q <= {24'h0, ctl_view};
                default: rdata_q <= BUS_UNMAPPED;
            endcase
        end
    end
    assign avs_readdata = rdata_q;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            addr_low_q <= ADDR_RESET;
            addr_high_q <= 7'h00;
        end
        else if (bus_wr && hit(avs_address, OFS_ADDR_LOW))
            addr_low_q <= avs_writedata[7:0];
        else if (bus_wr && hit(avs_address, OFS_ADDR_HIGH))
            addr_high_q <= avs_writedata[6:0];
    end

    assign cap_rd = (state_q == FPA_WAIT) && rd_q && arr_done;

    // Data word has no reset: it holds whatever was last written or read
    always_ff @(posedge mclk)
    begin
        if (cap_rd)
        begin
            data_low_q <= rd_ok ? arr_rdata[7:0] : 8'h00;
            data_high_q <= rd_ok ? arr_rdata[13:8] : 6'h00;
        end
        else if (bus_wr && hit(avs_address, OFS_DATA_LOW))
            data_low_q <= avs_writedata[7:0];
        else if (bus_wr && hit(avs_address, OFS_DATA_HIGH))
            data_high_q <= avs_writedata[5:0];
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            config_space_select_q <= 1'b0;
            lwlo_q <= 1'b0;
            wren_q <= 1'b0;
        end
        else if (bus_wr && hit(avs_address, OFS_CONTROL) && !wr_q)
        begin
            config_space_select_q <= avs_writedata[CTL_CONFIG_SPACE_SELECT];
            lwlo_q <= avs_writedata[CTL_LWLO];
            wren_q <= avs_writedata[CTL_WREN];
        end
    end

    // FREE clears by hardware after the erase completes
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            free_q <= 1'b0;
        else if (bus_wr && hit(avs_address, OFS_CONTROL) && !wr_q)
            free_q <= avs_writedata[CTL_FREE];
        else if (state_q == FPA_WAIT && wr_q && arr_done && free_q)
            free_q <= 1'b0;
    end

    // Error set wins over a software clear in the same cycle
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            wrerr_q <= 1'b0;
        else if (state_q == FPA_WAIT && wr_q && arr_done && arr_fail)
            wrerr_q <= 1'b1;
        else if (bus_wr && hit(avs_address, OFS_CONTROL))
            wrerr_q <= avs_writedata[CTL_WRERR];
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
        end
        else if (state_q == FPA_WAIT && arr_done)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
        end
        else if (wr_go)
            wr_q <= 1'b1;
        else if (bus_wr && hit(avs_address, OFS_CONTROL)
                 && avs_writedata[CTL_RD] && !wr_q && !rd_q)
            rd_q <= 1'b1;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            state_q <= FPA_IDLE;
        else
        begin
            case (state_q)
                FPA_IDLE:
                    if (wr_q || rd_q)
                        state_q <= FPA_REQ;
                FPA_REQ:
                    state_q <= FPA_WAIT;
                FPA_WAIT:
                    if (arr_done)
                        state_q <= FPA_IDLE;
                default:
                    state_q <= FPA_IDLE;
            endcase
        end
    end

    // Request is held for the whole operation
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            arr_req <= 1'b0;
            arr_we <= 1'b0;
            arr_erase <= 1'b0;
            arr_latch_only <= 1'b0;
            arr_addr <= 16'h0000;
            arr_wdata <= 14'h0000;
        end
        else if (state_q == FPA_IDLE && (wr_q || rd_q))
        begin
            // Writes to read-only config words never reach the array
            arr_req <= rd_q ? rd_ok : wr_ok;
            arr_we <= wr_q && !free_q;
            arr_erase <= wr_q && free_q;
            arr_latch_only <= wr_q && lwlo_q && !free_q;
            arr_addr <= eff_addr;
            arr_wdata <= {data_high_q, data_low_q};
        end
        else if (state_q == FPA_WAIT && arr_done)
            arr_req <= 1'b0;
    end
endmodule

// *** fpa_checker.sv ***
// Checker for fpa_top: bus answer, read-back widths, array requests.
// Assumes the master holds each request until waitrequest is low.
`timescale 1ns/1ps
module fpa_checker
    import fpa_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic arr_req,
    input wire logic arr_we,
    input wire logic arr_erase,
    input wire logic [15:0] arr_addr,
    input wire logic arr_done
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    logic ack;
    assign ack = avs_read && !avs_waitrequest;
    chk_wait_first: assert property ($rose(avs_read) |-> avs_waitrequest)
        else $error("read answered without a wait");
    chk_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest)
        else $error("access waited more than one cycle");
    chk_data_high: assert property (ack && avs_address == OFS_DATA_HIGH
        |-> avs_readdata[31:6] == 26'h0)
        else $error("data high upper bits not zero");
    chk_addr_high: assert property (ack && avs_address == OFS_ADDR_HIGH
        |-> avs_readdata[31:7] == 25'h1)
        else $error("address high bit 7 not one");
    chk_low_bytes: assert property (ack && (avs_address == OFS_DATA_LOW
        || avs_address == OFS_ADDR_LOW) |-> avs_readdata[31:8] == 24'h0)
        else $error("low register wider than a byte");
    chk_cfg_read_set: assert property (arr_req && !arr_we && !arr_erase
        && arr_addr[15] |-> arr_addr <= CFG_WORD_LAST
        && arr_addr != 16'h8004 && arr_addr != 16'h8005)
        else $error("config read outside allowed set");
    chk_cfg_write_set: assert property (arr_req && arr_we && arr_addr[15]
        |-> arr_addr <= CFG_USER_ID_LAST)
        else $error("config write outside user ID");
    chk_req_hold: assert property (arr_req && !arr_done
        |=> arr_req && $stable(arr_addr))
        else $error("array request dropped or moved");
    cover property (ack && avs_address == OFS_DATA_LOW);
    cover property (arr_req && arr_we && arr_addr[15]);
    cover property (arr_done && !arr_req);
endmodule
bind fpa_top fpa_checker u_chk (.mclk(mclk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .arr_req(arr_req), .arr_we(arr_we), .arr_erase(arr_erase),
    .arr_addr(arr_addr), .arr_done(arr_done));

// *** fpa_array_model.sv ***
// Flash array model: answers each request with a done pulse.
// Read word is only valid in the done cycle; kick gives a bare pulse.
`timescale 1ns/1ps
module fpa_array_model
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic arr_req,
    input wire logic arr_we,
    input wire logic [15:0] arr_addr,
    input wire logic [13:0] arr_wdata,
    input wire logic kick,
    output logic [13:0] arr_rdata,
    output logic arr_done,
    output logic arr_fail
);
    logic [13:0] mem [32];
    logic [1:0] cnt_q;
    logic [4:0] idx;
    assign idx = {arr_addr[15], arr_addr[3:0]};
    assign arr_fail = 1'b0;
    initial
    begin
        for (int i = 0; i < 32; i++)
            mem[i] = 14'h2a00 | 14'(i);
    end
    // Plain always: the array is also preset by the initial block
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_q <= 2'h0;
            arr_done <= 1'b0;
            arr_rdata <= 14'h0;
        end
        else
        begin
            cnt_q <= arr_req ? cnt_q + 2'h1 : 2'h0;
            arr_done <= (arr_req && cnt_q == 2'h2) || kick;
            // Not a stale word outside done
            arr_rdata <= (arr_req && cnt_q == 2'h2) ? mem[idx] : ~arr_rdata;
            if (arr_done && arr_req && arr_we)
                mem[idx] <= arr_wdata;
        end
    end
endmodule

// *** flash_program_memory_access_bench.sv ***
// Self-checking bench for fpa_top beside the array model.
// Assumes the array model answers each request with a one-cycle done.
`timescale 1ns/1ps
module flash_program_memory_access_bench
    import fpa_pkg::*;
;
    typedef struct {logic [5:0] a; logic [7:0] d; logic [31:0] e;} fpa_row_t;
    logic mclk = 0, rst_b = 0, rd = 0, wr = 0, kick = 0, got;
    logic [5:0] adr = 6'h0;
    logic [31:0] wd = 32'h0, rdat, rq;
    logic [13:0] wdat, rdata, word;
    logic [15:0] aa, seen;
    logic req, we, er, lo, done, fail, wq;
    logic [2:0] kind;
    int miscompares = 0, samples_checked = 0, cycles = 0;
    fpa_row_t rows [6] = '{'{OFS_DATA_LOW, 8'ha5, 32'ha5},
        '{OFS_DATA_HIGH, 8'hff, 32'h3f}, '{OFS_ADDR_LOW, 8'h5a, 32'h5a},
        '{OFS_ADDR_HIGH, 8'h7f, 32'hff}, '{OFS_ADDR_HIGH, 8'h00, 32'h80},
        '{6'h3c, 8'h77, 32'h0}};
    fpa_top uut (.mclk(mclk), .rst_b(rst_b), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
        .avs_byteenable(4'h1), .avs_readdata(rq), .avs_waitrequest(wq),
        .arr_req(req), .arr_we(we), .arr_erase(er), .arr_latch_only(lo),
        .arr_addr(aa), .arr_wdata(wdat), .arr_rdata(rdata), .arr_done(done),
        .arr_fail(fail));
    fpa_array_model u_arr (.mclk(mclk), .rst_b(rst_b), .arr_req(req),
        .arr_we(we), .arr_addr(aa), .arr_wdata(wdat), .kick(kick),
        .arr_rdata(rdata), .arr_done(done), .arr_fail(fail));
    initial
    begin
        forever #12.5 mclk = ~mclk;
    end
    task automatic print_verdict();
        $display("checked %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e)
        begin
            $display("ERROR %s expected %h seen %h", n, e, s);
            miscompares++;
        end
    endtask
    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [5:0] a,
        input logic [7:0] d);
        @(posedge mclk);
        adr <= a;
        wd <= {24'h0, d};
        rd <= !w;
        wr <= w;
        do @(posedge mclk); while (wq !== 1'b0);
        rdat = rq;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic op(input logic [7:0] c);
        bus(1'b1, OFS_CONTROL, c);
        got = 0;
        repeat (8)
        begin
            @(negedge mclk);
            if (req === 1'b1)
            begin
                got = 1;
                seen = aa;
                kind = {er, lo, we};
            end
        end
        // Refused operation never sees done unless pulsed
        if (!got)
        begin
            @(posedge mclk) kick <= 1'b1;
            @(posedge mclk) kick <= 1'b0;
        end
        repeat (3) @(posedge mclk);
        bus(1'b0, OFS_DATA_LOW, 8'h0);
        word[7:0] = rdat[7:0];
        bus(1'b0, OFS_DATA_HIGH, 8'h0);
        word[13:8] = rdat[5:0];
    endtask
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            print_verdict();
        end
    end
    initial
    begin
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        bus(1'b0, OFS_ADDR_LOW, 8'h0);
        check("addr_low_reset", rdat, 32'h0);
        bus(1'b0, OFS_ADDR_HIGH, 8'h0);
        check("addr_high_reset", rdat, 32'h80);
        $display("test reset done");
        foreach (rows[i])
        begin
            bus(1'b1, rows[i].a, rows[i].d);
            bus(1'b0, rows[i].a, 8'h0);
            check("row", rdat, rows[i].e);
        end
        $display("test registers done");
        bus(1'b1, OFS_ADDR_HIGH, 8'h01);
        bus(1'b1, OFS_ADDR_LOW, 8'h03);
        op(8'h01);
        check("prog_addr", seen, 16'h0103);
        check("prog_word", word, 14'h2a03);
        check("prog_kind", kind, 3'b000);
        bus(1'b1, OFS_ADDR_HIGH, 8'h00);
        for (int i = 0; i < 9; i++)
        begin
            bus(1'b1, OFS_ADDR_LOW, 8'(i));
            bus(1'b1, OFS_DATA_LOW, 8'hff);
            op(8'h41);
            check("cfg_req", got, i < 4 || i > 5);
            if (got)
                check("cfg_addr", seen, 16'h8000 | 16'(i));
            check("cfg_word", word, (i < 4 || i > 5) ? 14'h2a10 | 14'(i) : 0);
        end
        $display("test config read done");
        for (int i = 1; i < 8; i += 6)
        begin
            bus(1'b1, OFS_ADDR_LOW, 8'(i));
            bus(1'b1, OFS_DATA_LOW, 8'h34);
            bus(1'b1, OFS_DATA_HIGH, 8'h12);
            bus(1'b1, OFS_CONTROL, 8'h44);
            bus(1'b0, OFS_CONTROL, 8'h0);
            check("ctl_view", rdat, 32'hc4);
            bus(1'b1, OFS_UNLOCK, UNLOCK_FIRST);
            bus(1'b1, OFS_UNLOCK, UNLOCK_SECOND);
            op(8'h46);
            check("cfg_wr_req", got, i == 1);
            if (got)
                check("cfg_wr_kind", kind, 3'b001);
            op(8'h41);
            check("cfg_verify", word, i == 1 ? 14'h1234 : 14'h2a17);
        end
        $display("test config write done");
        print_verdict();
    end
endmodule
